// ==== pkg/tcr_params.svh ====
// Offsets, field positions, reset values and timing counts of the command front end
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
// Device code in instruction bits 3..8
`define TCR_DEV_CODE 6'h3e
// Command register layout (bus bits 00..09)
`define TCR_CMD_W 10
`define TCR_USEL_LO 0
`define TCR_USEL_HI 2
`define TCR_DIR_BIT 3
`define TCR_GO_BIT 4
`define TCR_FUNC_LO 5
`define TCR_FUNC_HI 8
`define TCR_IEN_BIT 9
`define TCR_CMD_RST 10'h000
// Format function code in the function field
`define TCR_FMT_FUNC 4'h7
// Clock period in ns
`define TCR_CLK_NS 100
// Strobe width 400 ns
`define TCR_STROBE_NS 400
`define TCR_STROBE_CYC (`TCR_STROBE_NS / `TCR_CLK_NS)
// Settle delay 5 us
`define TCR_SETTLE_NS 5000
`define TCR_SETTLE_CYC (`TCR_SETTLE_NS / `TCR_CLK_NS)
// Blanking 10 us
`define TCR_BLANK_NS 10000
`define TCR_BLANK_CYC (`TCR_BLANK_NS / `TCR_CLK_NS)
// Rate window 70 us
`define TCR_RATE_NS 70000
`define TCR_RATE_CYC (`TCR_RATE_NS / `TCR_CLK_NS)
// Up-to-speed delay 120 ms
`define TCR_SPEED_MS 120
`define TCR_SPEED_CYC (`TCR_SPEED_MS * 10000)
// Format clock 120 kc: half period in cycles (rounded down)
`define TCR_FMT_KHZ 120
`define TCR_FMT_HALF (10000 / (2 * `TCR_FMT_KHZ))
`endif

// ==== pkg/tcr_pkg.sv ====
// Types shared by the command front end
package tcr_pkg;
   typedef logic [9:0] tcr_cmd_t;
   typedef logic [2:0] tcr_unit_t;
   typedef enum logic [1:0] {
      TCR_SPD_IDLE = 2'b00,
      TCR_SPD_WAIT = 2'b01,
      TCR_SPD_RATE = 2'b10,
      TCR_SPD_UP = 2'b11
   } tcr_spd_e;
endpackage

// ==== logic/tcr_command_ctrl.sv ====
// Command register, unit select, motion sequencing and timing pulses
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tcr_command_ctrl #(
   parameter int SPEED_CYC = `TCR_SPEED_CYC,
   parameter int SETTLE_CYC = `TCR_SETTLE_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Processor I/O bus
   input wire logic [5:0] devCode,
   input wire logic ioPulseOne,
   input wire logic ioPulseTwo,
   input wire logic ioPulseFour,
   input wire logic powerClear,
   input wire logic [9:0] busIn,
   output logic [9:0] busOut,
   output logic busOutEn,
   output logic irqRequest,
   // Operator switch and word counter
   input wire logic maintenanceSwitch,
   input wire logic wordCounterBitLow,
   input wire logic writeRequest,
   // Transports
   input wire logic timingTrackEdge,
   output logic [7:0] unitSelect,
   output logic forwardDir,
   output logic reverseDir,
   output logic goOut,
   output logic stopOut,
   output logic timingPulseA,
   output logic timingPulseB,
   output logic timingTrackWrite,
   output logic writeWordEnableFf,
   output logic settleDelayLevel,
   output logic upToSpeed
);
   import tcr_pkg::*;

   localparam logic [3:0] STRB = 4'(`TCR_STROBE_CYC);
   localparam logic [5:0] FMTH = 6'(`TCR_FMT_HALF);
   localparam logic [7:0] BLNK = 8'(`TCR_BLANK_CYC);
   localparam logic [9:0] RATE = 10'(`TCR_RATE_CYC);

   // Pin synchronisers, three stages each
   logic [2:0] edgeSync_r;
   logic [2:0] fmtSync_r;
   logic [2:0] c2Sync_r;
   logic edgeSeen_r;
   logic fmtLvl_r;
   logic c2Lvl_r;
   logic trackRise;
   logic trackFall; // Falling track edge, agreed by stages two and three
   logic c2Fall;

   // Command register and motion state
   tcr_cmd_t cmd_r;
   logic motionFf_r;
   logic [3:0] clrCnt_r;
   logic [3:0] rdCnt_r;
   logic [7:0] settleCnt_r;
   logic devHit;

   // Timing state
   logic [5:0] fmtCnt_r;
   logic fmtClk_r;
   logic divLo_r;
   logic divHi_r;
   logic [7:0] blankCnt_r;
   logic fmtEnable;
   logic fmtTick;

   // Up-to-speed sequencer
   tcr_spd_e spd_r;
   logic [20:0] spdCnt_r;

   assign devHit = (devCode == `TCR_DEV_CODE);
   // Edges count only once stages two and three agree on the new level
   assign trackRise = edgeSync_r[2] & edgeSync_r[1] & ~edgeSeen_r;
   assign trackFall = ~edgeSync_r[2] & ~edgeSync_r[1] & edgeSeen_r;
   assign c2Fall = ~c2Sync_r[2] & ~c2Sync_r[1] & c2Lvl_r;
   assign fmtEnable = fmtLvl_r & cmd_r[`TCR_GO_BIT] &
      (cmd_r[`TCR_FUNC_HI:`TCR_FUNC_LO] == `TCR_FMT_FUNC);
   assign fmtTick = fmtEnable && (fmtCnt_r == FMTH - 6'h01);

   // Synchronise pins; a change counts when stages two and three agree
   always_ff @(posedge mclk) begin
      edgeSync_r <= {edgeSync_r[1:0], timingTrackEdge};
      fmtSync_r <= {fmtSync_r[1:0], maintenanceSwitch};
      c2Sync_r <= {c2Sync_r[1:0], wordCounterBitLow};
      if (reset) begin
         edgeSeen_r <= 1'b0;
         fmtLvl_r <= 1'b0;
         c2Lvl_r <= 1'b0;
      end else begin
         if (edgeSync_r[2] == edgeSync_r[1]) edgeSeen_r <= edgeSync_r[2];
         if (fmtSync_r[2] == fmtSync_r[1]) fmtLvl_r <= fmtSync_r[2];
         if (c2Sync_r[2] == c2Sync_r[1]) c2Lvl_r <= c2Sync_r[2];
      end
   end

   // Command register: clear, exclusive-OR load
   always_ff @(posedge mclk) begin
      if (reset || powerClear) begin
         cmd_r <= `TCR_CMD_RST;
      end else if (devHit && ioPulseOne) begin
         cmd_r <= `TCR_CMD_RST;
      end else if (devHit && ioPulseFour) begin
         cmd_r <= cmd_r ^ busIn;
      end
   end

   // Clear and read strobes of 400 ns
   always_ff @(posedge mclk) begin
      if (reset) begin
         clrCnt_r <= 4'h0;
         rdCnt_r <= 4'h0;
      end else begin
         if (devHit && ioPulseOne) clrCnt_r <= STRB;
         else if (clrCnt_r != 4'h0) clrCnt_r <= clrCnt_r - 4'h1;
         // Pulse edge plus three more cycles gives a 400 ns strobe
         if (devHit && ioPulseTwo) rdCnt_r <= STRB - 4'h1;
         else if (rdCnt_r != 4'h0) rdCnt_r <= rdCnt_r - 4'h1;
      end
   end

   // Read-back onto the bus during the read strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         busOut <= 10'h000;
         busOutEn <= 1'b0;
      end else begin
         busOutEn <= (rdCnt_r != 4'h0) || (devHit && ioPulseTwo);
         busOut <= ((rdCnt_r != 4'h0) || (devHit && ioPulseTwo)) ?
            cmd_r : 10'h000;
      end
   end

   // Settle delay after clear or load; motion flip-flop at its end
   always_ff @(posedge mclk) begin
      if (reset) begin
         settleCnt_r <= 8'h00;
         motionFf_r <= 1'b0;
      end else begin
         if (devHit && (ioPulseOne || ioPulseFour)) begin
            settleCnt_r <= 8'(SETTLE_CYC);
         end else if (settleCnt_r != 8'h00) begin
            settleCnt_r <= settleCnt_r - 8'h01;
         end
         if (!cmd_r[`TCR_GO_BIT]) begin
            motionFf_r <= 1'b0;
         end else if (settleCnt_r == 8'h01) begin
            motionFf_r <= cmd_r[`TCR_GO_BIT];
         end
      end
   end

   // Transport control outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         unitSelect <= 8'h00;
         forwardDir <= 1'b0;
         reverseDir <= 1'b0;
         goOut <= 1'b0;
         stopOut <= 1'b0;
         settleDelayLevel <= 1'b0;
         irqRequest <= 1'b0;
      end else begin
         unitSelect <= 8'h01 << cmd_r[`TCR_USEL_HI:`TCR_USEL_LO];
         settleDelayLevel <= (settleCnt_r != 8'h00);
         if ((clrCnt_r != 4'h0) || !cmd_r[`TCR_GO_BIT] ||
             (settleCnt_r != 8'h00) || !motionFf_r) begin
            forwardDir <= 1'b0;
            reverseDir <= 1'b0;
         end else begin
            forwardDir <= ~cmd_r[`TCR_DIR_BIT];
            reverseDir <= cmd_r[`TCR_DIR_BIT];
         end
         goOut <= (settleCnt_r == 8'h00) && cmd_r[`TCR_GO_BIT];
         stopOut <= (settleCnt_r == 8'h00) && !cmd_r[`TCR_GO_BIT];
         irqRequest <= cmd_r[`TCR_IEN_BIT];
      end
   end

   // Format clock and two-stage divider
   always_ff @(posedge mclk) begin
      if (reset || !fmtEnable) begin
         fmtCnt_r <= 6'h00;
         fmtClk_r <= 1'b0;
         divLo_r <= 1'b0;
         divHi_r <= 1'b0;
      end else begin
         fmtCnt_r <= fmtTick ? 6'h00 : fmtCnt_r + 6'h01;
         if (fmtTick) begin
            fmtClk_r <= ~fmtClk_r;
            if (!fmtClk_r) begin
               divLo_r <= ~divLo_r;
               if (!divLo_r) divHi_r <= ~divHi_r;
            end
         end
      end
   end

   // Write word enable: set and release only at counter-low fall
   always_ff @(posedge mclk) begin
      if (reset) begin
         writeWordEnableFf <= 1'b0;
      end else if (c2Fall) begin
         writeWordEnableFf <= writeRequest;
      end
   end

   // Timing pulses, blanking and track write data
   always_ff @(posedge mclk) begin
      if (reset) begin
         timingPulseA <= 1'b0;
         timingPulseB <= 1'b0;
         timingTrackWrite <= 1'b0;
         blankCnt_r <= 8'h00;
      end else begin
         timingTrackWrite <= fmtEnable & divHi_r;
         timingPulseA <= 1'b0;
         timingPulseB <= 1'b0;
         if (blankCnt_r != 8'h00) blankCnt_r <= blankCnt_r - 8'h01;
         if (fmtEnable) begin
            if (fmtTick && !fmtClk_r && !divLo_r) begin
               timingPulseA <= ~divHi_r;
               timingPulseB <= divHi_r;
            end
         end else if (spd_r == TCR_SPD_UP && blankCnt_r == 8'h00 &&
                      (trackRise || trackFall)) begin
            // Rising track edge gives one pulse, falling edge the other
            timingPulseA <= trackRise;
            timingPulseB <= trackFall;
            blankCnt_r <= BLNK;
         end
      end
   end

   // Up-to-speed: 120 ms wait, then two rising edges within 70 us
   always_ff @(posedge mclk) begin
      if (reset || !motionFf_r) begin
         spd_r <= TCR_SPD_IDLE;
         spdCnt_r <= 21'h000000;
      end else if (devHit && ioPulseFour &&
                   (busIn[`TCR_GO_BIT:`TCR_USEL_LO] != 5'h00)) begin
         spd_r <= TCR_SPD_WAIT;
         spdCnt_r <= 21'(SPEED_CYC);
      end else begin
         case (spd_r)
            TCR_SPD_IDLE: begin
               spd_r <= TCR_SPD_WAIT;
               spdCnt_r <= 21'(SPEED_CYC);
            end
            TCR_SPD_WAIT: begin
               if (spdCnt_r != 21'h000000) spdCnt_r <= spdCnt_r - 21'h1;
               else if (trackRise) begin
                  spd_r <= TCR_SPD_RATE;
                  spdCnt_r <= 21'(RATE);
               end
            end
            TCR_SPD_RATE: begin
               if (trackRise) spd_r <= TCR_SPD_UP;
               else if (spdCnt_r == 21'h000000) spd_r <= TCR_SPD_WAIT;
               else spdCnt_r <= spdCnt_r - 21'h1;
            end
            default: spd_r <= TCR_SPD_UP;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) upToSpeed <= 1'b0;
      else upToSpeed <= (spd_r == TCR_SPD_UP);
   end
endmodule
`default_nettype wire

// ==== testbench/tcr_command_ctrl_sva.sv ====
// Port assertions for the command front end
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tcr_command_ctrl_sva (
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic reset,
   input wire logic [5:0] devCode,
   input wire logic ioPulseOne,
   input wire logic ioPulseTwo,
   input wire logic ioPulseFour,
   input wire logic [9:0] busIn,
   input wire logic [9:0] busOut,
   input wire logic busOutEn,
   input wire logic irqRequest,
   // Transport side
   input wire logic [7:0] unitSelect,
   input wire logic forwardDir,
   input wire logic reverseDir,
   input wire logic goOut,
   input wire logic stopOut,
   input wire logic timingPulseA,
   input wire logic timingPulseB,
   input wire logic settleDelayLevel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Instruction hits
   sequence s_clr; devCode == `TCR_DEV_CODE && ioPulseOne; endsequence
   sequence s_rd; devCode == `TCR_DEV_CODE && ioPulseTwo; endsequence
   sequence s_ld; devCode == `TCR_DEV_CODE && ioPulseFour; endsequence
   // Settle under way since last edge
   sequence s_hold; settleDelayLevel && $past(settleDelayLevel); endsequence
   // Cycles since the last timing pulse, saturating
   logic [7:0] gapCnt_r;
   always_ff @(posedge mclk) begin
      if (reset) gapCnt_r <= 8'hff;
      else if (timingPulseA || timingPulseB) gapCnt_r <= 8'h00;
      else if (gapCnt_r != 8'hff) gapCnt_r <= gapCnt_r + 8'h01;
   end
   a_read_strobe: assert property (
      s_rd |=> busOutEn [*4] ##1 !busOutEn) else $error("read strobe width");
   a_pulse_blank: assert property (
      (timingPulseA || timingPulseB) |-> gapCnt_r >= 8'(`TCR_BLANK_CYC))
      else $error("pulse inside blanking");
   a_bus_quiet: assert property (
      !busOutEn |-> busOut == 10'h000) else $error("bus driven idle");
   a_clear_unit: assert property (
      s_clr |=> ##2 unitSelect == 8'h01 && !irqRequest)
      else $error("clear not unit zero");
   a_settle_start: assert property (
      (s_clr or s_ld) |=> ##2 settleDelayLevel) else $error("no settle");
   a_settle_motion: assert property (
      s_hold |-> !goOut && !stopOut) else $error("motion in settle");
   a_settle_dir: assert property (
      s_hold |-> !forwardDir && !reverseDir) else $error("dir in settle");
   a_dir_excl: assert property (
      !(forwardDir && reverseDir)) else $error("both directions");
   a_go_stop: assert property (
      !(goOut && stopOut)) else $error("go and stop");
   a_unit_onehot: assert property (
      $onehot0(unitSelect)) else $error("unit lines not one-hot");
   a_pulse_pair: assert property (
      !(timingPulseA && timingPulseB)) else $error("pulses overlap");
   a_irq_flip: assert property (
      s_ld ##0 busIn[9] && !ioPulseOne |=> ##2
      irqRequest != $past(irqRequest, 3)) else $error("irq not toggled");
endmodule
bind tcr_command_ctrl tcr_command_ctrl_sva tcr_command_ctrl_sva_inst (
   .mclk, .reset, .devCode, .ioPulseOne, .ioPulseTwo, .ioPulseFour,
   .busIn, .busOut, .busOutEn, .irqRequest, .unitSelect, .forwardDir,
   .reverseDir, .goOut, .stopOut, .timingPulseA, .timingPulseB,
   .settleDelayLevel
);
`default_nettype wire

// ==== testbench/tcr_transport_model.sv ====
// Transport model: track edges while moving, word counter bit
`timescale 1ns/100ps
`default_nettype none
module tcr_transport_model #(
   parameter int EDGE_CYC = 166 // Track half period, longer than blanking
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Motion from the controller
   input wire logic goOut,
   // Track and counter levels
   output logic timingTrackEdge,
   output logic wordCounterBitLow
);
   int cnt_r; // Cycle counter
   // Track level frozen while stopped
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r <= 0;
         timingTrackEdge <= 1'b0;
         wordCounterBitLow <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == EDGE_CYC - 1) ? 0 : cnt_r + 1;
         if (cnt_r == 0) begin
            wordCounterBitLow <= !wordCounterBitLow;
            if (goOut)
               timingTrackEdge <= !timingTrackEdge;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the command front end
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tb;
   logic mclk = 1'b0; // 10 MHz clock
   logic reset = 1'b1; // Synchronous reset
   logic [5:0] devCode = 6'h00; // Device code field
   logic ioPulseOne = 1'b0, ioPulseTwo = 1'b0, ioPulseFour = 1'b0;
   logic powerClear = 1'b0, maintenanceSwitch = 1'b0, writeRequest = 1'b0;
   logic [9:0] busIn = 10'h000, busOut, v;
   logic [7:0] unitSelect;
   logic busOutEn, irqRequest, forwardDir, reverseDir, goOut, stopOut;
   logic timingPulseA, timingPulseB, timingTrackWrite, writeWordEnableFf;
   logic settleDelayLevel, upToSpeed, timingTrackEdge, wordCounterBitLow;
   logic [8:0] fl; // Flags for the wait task
   int errors = 0, totalChecks = 0;
   assign fl = {timingTrackWrite, upToSpeed, timingPulseA, timingPulseB,
      goOut, stopOut, writeWordEnableFf, reverseDir, busOutEn};
   always #50 mclk = !mclk;
   tcr_command_ctrl #(.SPEED_CYC(200)) tcr_command_ctrl_inst (
      .mclk, .reset, .devCode, .ioPulseOne, .ioPulseTwo, .ioPulseFour,
      .powerClear, .busIn, .busOut, .busOutEn, .irqRequest,
      .maintenanceSwitch, .wordCounterBitLow, .writeRequest,
      .timingTrackEdge, .unitSelect, .forwardDir, .reverseDir, .goOut,
      .stopOut, .timingPulseA, .timingPulseB, .timingTrackWrite,
      .writeWordEnableFf, .settleDelayLevel, .upToSpeed);
   tcr_transport_model tcr_transport_model_inst (
      .mclk, .reset, .goOut, .timingTrackEdge, .wordCounterBitLow);
   // Verdict and end of run
   task results;
      $display("errors %0d checks %0d", errors, totalChecks);
      if (errors == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Compare and count
   task chk(input string n, input logic [9:0] e, input logic [9:0] g);
      totalChecks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // Bounded wait for a flag level
   task waitf(input int i, input logic s);
      int k;
      k = 0;
      while (fl[i] !== s && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      chk("wait", 10'(s), 10'(fl[i]));
      if (fl[i] !== s)
         results();
   endtask
   // One instruction with a one-cycle pulse
   task iot(input logic [5:0] c, input int p, input logic [9:0] d);
      @(negedge mclk);
      devCode = c;
      busIn = d;
      ioPulseOne = (p == 1);
      ioPulseTwo = (p == 2);
      ioPulseFour = (p == 4);
      @(negedge mclk);
      {ioPulseOne, ioPulseTwo, ioPulseFour} = 3'h0;
      @(negedge mclk);
   endtask
   // Read the command register
   task rd;
      iot(`TCR_DEV_CODE, 2, 10'h000);
      waitf(0, 1'b1);
      v = busOut;
      repeat (6) @(negedge mclk);
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      rd();
      chk("cmd", 10'h000, v);
      chk("unit", 10'h001, 10'(unitSelect));
      for (int u = 0; u < 8; u++) begin
         iot(`TCR_DEV_CODE, 1, 10'h000);
         iot(`TCR_DEV_CODE, 4, 10'(u));
         repeat (2) @(negedge mclk);
         chk("unit", 10'(1 << u), 10'(unitSelect));
         rd();
         chk("cmd", 10'(u), v);
      end
      iot(`TCR_DEV_CODE, 4, 10'h005);
      rd();
      chk("cmd", 10'h002, v);
      iot(6'h3d, 4, 10'h3ff);
      rd();
      chk("cmd", 10'h002, v);
      iot(`TCR_DEV_CODE, 1, 10'h000);
      iot(`TCR_DEV_CODE, 4, 10'h210);
      @(negedge mclk);
      chk("settle", 10'h001, 10'(settleDelayLevel));
      chk("go", 10'h000, 10'(goOut));
      chk("irq", 10'h001, 10'(irqRequest));
      waitf(4, 1'b1);
      chk("fwd", 10'h001, 10'(forwardDir));
      waitf(7, 1'b1);
      waitf(6, 1'b1);
      waitf(5, 1'b1);
      writeRequest = 1'b1;
      waitf(2, 1'b1);
      writeRequest = 1'b0;
      waitf(2, 1'b0);
      iot(`TCR_DEV_CODE, 4, 10'h008);
      waitf(1, 1'b1);
      chk("fwd", 10'h000, 10'(forwardDir));
      iot(`TCR_DEV_CODE, 4, 10'h010);
      waitf(3, 1'b1);
      chk("rev", 10'h000, 10'(reverseDir));
      powerClear = 1'b1;
      @(negedge mclk);
      powerClear = 1'b0;
      rd();
      chk("cmd", 10'h000, v);
      maintenanceSwitch = 1'b1;
      iot(`TCR_DEV_CODE, 4, 10'h0f0);
      waitf(6, 1'b1);
      waitf(8, 1'b1);
      waitf(8, 1'b0);
      results();
   end
endmodule
`default_nettype wire
